//--- acs_cfg.svh
// acs_cfg.svh: timing and field constants for the conversion sequencer.
// assumes: included by bare name from the design file.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// =====================================================================
// control word field positions
`define ACS_CCS_HI       15
`define ACS_CCS_LO       14
`define ACS_STS_HI       13
`define ACS_STS_LO       12
`define ACS_PWR_OFF_BIT  0
`define ACS_CTRL_RESET   16'h0000

// =====================================================================
// phase lengths in half cpu periods, index = {ccs, sts}
`define ACS_SMP_00 {11'd400, 11'd200, 11'd140, 11'd120}
`define ACS_CMP_00 {11'd280, 11'd280, 11'd280, 11'd240}
`define ACS_EXT_00 {11'd44,  11'd52,  11'd16,  11'd28}
`define ACS_SMP_11 {11'd800, 11'd400, 11'd280, 11'd240}
`define ACS_CMP_11 {11'd560, 11'd560, 11'd560, 11'd480}
`define ACS_EXT_11 {11'd52,  11'd100, 11'd28,  11'd52}
`define ACS_SMP_10 {11'd1600, 11'd800, 11'd560, 11'd480}
`define ACS_CMP_10 {11'd1120, 11'd1120, 11'd1120, 11'd960}
`define ACS_EXT_10 {11'd164, 11'd196, 11'd52,  11'd100}
`define ACS_MIN_TOTAL_HALF 388
`define ACS_HALF_PER_CLK   2
`define ACS_RES_BITS       10

`endif

//--- acs_pkg.sv
// acs_pkg.sv: types for the conversion sequencer.
// assumes: acs_cfg.svh on the include path.
`default_nettype none
package acs_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_COMPARE, ST_EXTRA} acs_state_t;
  typedef enum logic [1:0] {CCS_FAST = 2'b00, CCS_RSVD = 2'b01,
                            CCS_SLOW = 2'b10, CCS_MID = 2'b11} acs_ccs_t;
endpackage : acs_pkg
`default_nettype wire

//--- acs_seq.sv
// acs_seq.sv: timing sequencer for one successive-approximation conversion.
// assumes: analog core outside gives comparator result, one clock, sync reset.
//
// What this block does
// - each conversion starts with a sample phase that charges the input capacitances.
// - after sampling, one comparison step per result bit resolves a 10-bit value.
// - phase lengths come from programmable settings counted in half cpu periods.
// - conversion-clock and sample-time selects sit in the upper four control bits.
// - all durations are counted in half-periods, two per cpu clock.
// - sample, comparison and an extra phase form one conversion; result loads at extra end.
// - with clock select 00 the phase lengths follow the fast timing table.
// - with clock select 11 the phase lengths follow the middle timing table.
// - with clock select 10 the phase lengths follow the slow timing table.
// - the shortest programmable conversion lasts 388 half-periods.
// - the result is a 10-bit code relative to the analog reference.
// - below analog ground reads 0x000, above the reference reads 0x3FF.
// - the power-off bit switches off the analog circuitry.
`include "acs_cfg.svh"
`default_nettype none

module acs_seq #(
  parameter int RES_BITS = `ACS_RES_BITS
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  input  wire logic [15:0]         i_converter_control_reg,
  input  wire logic                i_start,
  input  wire logic                i_cmp_above,
  input  wire logic                i_below_ground,
  input  wire logic                i_above_reference,
  output logic                     o_sample_en,
  output logic                     o_compare_en,
  output logic [RES_BITS-1:0]      o_dac_code,
  output logic                     o_analog_on,
  output logic                     o_busy,
  output logic                     o_result_valid,
  output logic                     o_config_error,
  output logic [RES_BITS-1:0]      o_result
);

  // =====================================================================
  // field decode
  logic [1:0]  conv_clock_select;
  logic [1:0]  sample_time_select;
  logic [10:0] smp_half;
  logic [10:0] cmp_half;
  logic [10:0] ext_half;
  logic [43:0] smp_tab;
  logic [43:0] cmp_tab;
  logic [43:0] ext_tab;

  assign conv_clock_select  = i_converter_control_reg[`ACS_CCS_HI:`ACS_CCS_LO];
  assign sample_time_select = i_converter_control_reg[`ACS_STS_HI:`ACS_STS_LO];

  always_comb begin
    case (acs_pkg::acs_ccs_t'(conv_clock_select))
      acs_pkg::CCS_FAST: begin
        smp_tab = `ACS_SMP_00;
        cmp_tab = `ACS_CMP_00;
        ext_tab = `ACS_EXT_00;
      end
      acs_pkg::CCS_MID: begin
        smp_tab = `ACS_SMP_11;
        cmp_tab = `ACS_CMP_11;
        ext_tab = `ACS_EXT_11;
      end
      acs_pkg::CCS_SLOW: begin
        smp_tab = `ACS_SMP_10;
        cmp_tab = `ACS_CMP_10;
        ext_tab = `ACS_EXT_10;
      end
      default: begin
        smp_tab = `ACS_SMP_00;
        cmp_tab = `ACS_CMP_00;
        ext_tab = `ACS_EXT_00;
      end
    endcase
    smp_half = smp_tab[sample_time_select*11 +: 11];
    cmp_half = cmp_tab[sample_time_select*11 +: 11];
    ext_half = ext_tab[sample_time_select*11 +: 11];
  end

  // half-periods are always even, so cycles = half / 2 exactly
  logic [9:0] smp_cyc;
  logic [9:0] cmp_cyc;
  logic [9:0] ext_cyc;
  assign smp_cyc = smp_half[10:1];
  assign cmp_cyc = cmp_half[10:1];
  assign ext_cyc = ext_half[10:1];

  // =====================================================================
  // sequencer state
  acs_pkg::acs_state_t   state_r, state_nxt;
  logic [9:0]            cnt_r, cnt_nxt;
  logic [9:0]            step_len_r, step_len_nxt;
  logic [9:0]            step_cnt_r, step_cnt_nxt;
  logic [3:0]            bit_r, bit_nxt;
  logic [RES_BITS-1:0]   sar_r, sar_nxt;
  logic [RES_BITS-1:0]   result_r, result_nxt;
  logic                  valid_r, valid_nxt;
  logic                  err_r, err_nxt;
  logic                  clamp_lo_r, clamp_lo_nxt;
  logic                  clamp_hi_r, clamp_hi_nxt;
  logic                  pwr_on_r, pwr_on_nxt;
  logic [RES_BITS-1:0]   trial;

  assign trial = sar_r | (RES_BITS'(1) << bit_r);

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    step_len_nxt = step_len_r;
    step_cnt_nxt = step_cnt_r;
    bit_nxt      = bit_r;
    sar_nxt      = sar_r;
    result_nxt   = result_r;
    valid_nxt    = 1'b0;
    err_nxt      = err_r;
    clamp_lo_nxt = clamp_lo_r;
    clamp_hi_nxt = clamp_hi_r;
    pwr_on_nxt   = ~i_converter_control_reg[`ACS_PWR_OFF_BIT];
    case (state_r)
      acs_pkg::ST_IDLE: begin
        if (i_start && pwr_on_r) begin
          // reserved select refuses to start rather than guess a timing
          if (conv_clock_select == 2'(acs_pkg::CCS_RSVD)) begin
            err_nxt = 1'b1;
          end else begin
            err_nxt      = 1'b0;
            state_nxt    = acs_pkg::ST_SAMPLE;
            cnt_nxt      = smp_cyc - 10'd1;
            step_len_nxt = 10'(cmp_cyc / 10'(RES_BITS));
            sar_nxt      = '0;
            bit_nxt      = 4'(RES_BITS - 1);
            clamp_lo_nxt = 1'b0;
            clamp_hi_nxt = 1'b0;
          end
        end
      end
      acs_pkg::ST_SAMPLE: begin
        // out-of-range detect latched while the input is still tracked
        clamp_lo_nxt = i_below_ground;
        clamp_hi_nxt = i_above_reference;
        if (cnt_r == 10'd0) begin
          state_nxt    = acs_pkg::ST_COMPARE;
          cnt_nxt      = cmp_cyc - 10'd1;
          step_cnt_nxt = step_len_r - 10'd1;
        end else begin
          cnt_nxt = cnt_r - 10'd1;
        end
      end
      acs_pkg::ST_COMPARE: begin
        // one bit decided per step; leftover cycles pad the phase end
        if (step_cnt_r == 10'd0 && bit_r != 4'hF) begin
          if (!i_cmp_above) begin
            sar_nxt = trial;
          end
          bit_nxt      = bit_r - 4'd1;
          step_cnt_nxt = step_len_r - 10'd1;
        end else if (step_cnt_r != 10'd0) begin
          step_cnt_nxt = step_cnt_r - 10'd1;
        end
        if (cnt_r == 10'd0) begin
          state_nxt = acs_pkg::ST_EXTRA;
          cnt_nxt   = ext_cyc - 10'd1;
        end else begin
          cnt_nxt = cnt_r - 10'd1;
        end
      end
      acs_pkg::ST_EXTRA: begin
        if (cnt_r == 10'd0) begin
          state_nxt = acs_pkg::ST_IDLE;
          valid_nxt = 1'b1;
          if (clamp_lo_r) begin
            result_nxt = '0;
          end else if (clamp_hi_r) begin
            result_nxt = '1;
          end else begin
            result_nxt = sar_r;
          end
        end else begin
          cnt_nxt = cnt_r - 10'd1;
        end
      end
      default: begin
        state_nxt = acs_pkg::ST_IDLE;
      end
    endcase
    if (!pwr_on_r) begin
      state_nxt = acs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r    <= acs_pkg::ST_IDLE;
      cnt_r      <= '0;
      step_len_r <= '0;
      step_cnt_r <= '0;
      bit_r      <= '0;
      sar_r      <= '0;
      result_r   <= '0;
      valid_r    <= 1'b0;
      err_r      <= 1'b0;
      clamp_lo_r <= 1'b0;
      clamp_hi_r <= 1'b0;
      pwr_on_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      step_len_r <= step_len_nxt;
      step_cnt_r <= step_cnt_nxt;
      bit_r      <= bit_nxt;
      sar_r      <= sar_nxt;
      result_r   <= result_nxt;
      valid_r    <= valid_nxt;
      err_r      <= err_nxt;
      clamp_lo_r <= clamp_lo_nxt;
      clamp_hi_r <= clamp_hi_nxt;
      pwr_on_r   <= pwr_on_nxt;
    end
  end

  // =====================================================================
  // registered outputs
  logic                sample_en_r;
  logic                compare_en_r;
  logic                busy_r;
  logic [RES_BITS-1:0] dac_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sample_en_r  <= 1'b0;
      compare_en_r <= 1'b0;
      busy_r       <= 1'b0;
      dac_r        <= '0;
    end else begin
      sample_en_r  <= (state_nxt == acs_pkg::ST_SAMPLE);
      compare_en_r <= (state_nxt == acs_pkg::ST_COMPARE);
      busy_r       <= (state_nxt != acs_pkg::ST_IDLE);
      dac_r        <= (bit_nxt == 4'hF) ? sar_nxt : (sar_nxt | (RES_BITS'(1) << bit_nxt));
    end
  end

  assign o_sample_en    = sample_en_r;
  assign o_compare_en   = compare_en_r;
  assign o_busy         = busy_r;
  assign o_dac_code     = dac_r;
  assign o_analog_on    = pwr_on_r;
  assign o_result_valid = valid_r;
  assign o_config_error = err_r;
  assign o_result       = result_r;

endmodule : acs_seq
`default_nettype wire

//--- acs_seq_properties.sv
// acs_seq_properties.sv: port assertions for the conversion sequencer.
// assumes: bound into acs_seq; one clock, sync active-high reset.
`default_nettype none
module acs_seq_properties #(
  parameter int RES_BITS = 10
) (
  input wire logic                i_clk,
  input wire logic                i_reset,
  input wire logic [15:0]         i_converter_control_reg,
  input wire logic                i_start,
  input wire logic                i_cmp_above,
  input wire logic                i_below_ground,
  input wire logic                i_above_reference,
  input wire logic                o_sample_en,
  input wire logic                o_compare_en,
  input wire logic [RES_BITS-1:0] o_dac_code,
  input wire logic                o_analog_on,
  input wire logic                o_busy,
  input wire logic                o_result_valid,
  input wire logic                o_config_error,
  input wire logic [RES_BITS-1:0] o_result
);
  // ==========================================================
  // busy length counter, cleared whenever busy drops
  int run_r;
  int run_nxt;
  always_comb begin
    run_nxt = (i_reset || !o_busy) ? 0 : run_r + 1;
  end
  always_ff @(posedge i_clk) begin
    run_r <= run_nxt;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // ==========================================================
  // properties
  a_sample_first: assert property ($rose(o_busy) |-> o_sample_en && !o_compare_en)
    else $error("conversion did not open with sampling");
  a_compare_follows: assert property ($rose(o_compare_en) |-> $past(o_sample_en))
    else $error("comparison not preceded by sampling");
  // first trial is the top bit alone, msb decided first
  a_first_trial: assert property ($rose(o_compare_en) |->
    o_dac_code == {1'b1, {(RES_BITS-1){1'b0}}})
    else $error("first comparison trial is not the top bit");
  // shortest sample phase is 120 half periods
  a_sample_len: assert property ($rose(o_compare_en) |-> run_r >= 60)
    else $error("sample phase too short");
  a_valid_pulse: assert property (o_result_valid |=> !o_result_valid)
    else $error("result valid longer than one cycle");
  a_valid_at_end: assert property (o_result_valid |-> !o_busy && $past(o_busy))
    else $error("result valid not at end of conversion");
  a_min_total: assert property (o_result_valid |-> run_r >= 194)
    else $error("conversion shorter than 388 half periods");
  a_result_hold: assert property (!o_result_valid |-> $stable(o_result))
    else $error("result changed without valid");
  a_config_refuse: assert property (i_start && !o_busy && o_analog_on &&
    !i_converter_control_reg[0] && i_converter_control_reg[15:14] == 2'h1
    |=> o_config_error && !o_busy) else $error("reserved clock select not refused");
  a_power_off: assert property (i_converter_control_reg[0] |=> !o_analog_on ##1 !o_busy)
    else $error("power off did not stop the converter");
  c_result: cover property (o_result_valid);
  c_config: cover property ($rose(o_config_error));
  c_abort: cover property ($fell(o_busy) && !o_result_valid);
endmodule : acs_seq_properties
bind acs_seq acs_seq_properties #(.RES_BITS(RES_BITS)) acs_seq_properties_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_converter_control_reg(i_converter_control_reg),
  .i_start(i_start), .i_cmp_above(i_cmp_above), .i_below_ground(i_below_ground),
  .i_above_reference(i_above_reference), .o_sample_en(o_sample_en),
  .o_compare_en(o_compare_en), .o_dac_code(o_dac_code), .o_analog_on(o_analog_on),
  .o_busy(o_busy), .o_result_valid(o_result_valid), .o_config_error(o_config_error),
  .o_result(o_result));
`default_nettype wire

//--- tb.sv
// tb.sv: self-checking bench for the conversion sequencer.
// assumes: config header, package, design and checker compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset, i_start, i_cmp_above, i_below_ground, i_above_reference;
  logic [15:0] i_converter_control_reg;
  logic [9:0] o_dac_code, o_result;
  logic o_sample_en, o_compare_en, o_analog_on, o_busy, o_result_valid, o_config_error;
  int failures, comparisons, ref_v, k;
  logic seen;
  // half periods; rows clock select 00, 11, 10, columns sample select 00..11
  int smp[12] = '{120, 140, 200, 400, 240, 280, 400, 800, 480, 560, 800, 1600};
  int cmp[12] = '{240, 280, 280, 280, 480, 560, 560, 560, 960, 1120, 1120, 1120};
  int ext[12] = '{28, 16, 52, 44, 52, 28, 100, 52, 100, 52, 196, 164};
  logic [1:0] ccs_of[3] = '{2'h0, 2'h3, 2'h2};
  acs_seq acs_seq_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_converter_control_reg(i_converter_control_reg), .i_start(i_start),
    .i_cmp_above(i_cmp_above), .i_below_ground(i_below_ground),
    .i_above_reference(i_above_reference), .o_sample_en(o_sample_en),
    .o_compare_en(o_compare_en), .o_dac_code(o_dac_code), .o_analog_on(o_analog_on),
    .o_busy(o_busy), .o_result_valid(o_result_valid), .o_config_error(o_config_error),
    .o_result(o_result));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // comparator lags a cycle; harmless as each step spans many cycles
  always @(posedge i_clk) begin
    i_cmp_above <= (o_dac_code > ref_v[9:0]);
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic start_with(input logic [15:0] ctl);
    @(posedge i_clk);
    i_converter_control_reg <= ctl;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
  endtask : start_with
  // kind 0 follows the comparator, 1 below ground, 2 above reference
  task automatic conv(input int i, input int kind);
    int ns = 0;
    int nc = 0;
    int nb = 0;
    logic [9:0] exp;
    ref_v = $urandom % 1024;
    exp = kind == 1 ? 10'h000 : kind == 2 ? 10'h3FF : ref_v[9:0];
    @(posedge i_clk);
    i_below_ground <= kind == 1;
    i_above_reference <= kind == 2;
    start_with({ccs_of[i / 4], 2'(i % 4), 12'h000});
    for (int n = 0; n < 1500 && o_result_valid !== 1'b1; n++) begin
      @(negedge i_clk);
      ns += (o_sample_en === 1'b1);
      nc += (o_compare_en === 1'b1);
      nb += (o_busy === 1'b1);
    end
    check(16'(o_result_valid), 16'h0001);
    check(16'(ns), 16'(smp[i] / 2));
    check(16'(nc), 16'(cmp[i] / 2));
    check(16'(nb - ns - nc), 16'(ext[i] / 2));
    check(16'(nb), 16'((smp[i] + cmp[i] + ext[i]) / 2));
    check(16'(o_result), 16'(exp));
  endtask : conv
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  initial begin
    {i_reset, i_start, i_below_ground, i_above_reference} = 4'h8;
    i_converter_control_reg = 16'h0000;
    ref_v = 0;
    void'($urandom(32'h0559AE45));
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    for (k = 0; k < 12; k++) conv(k, 0);
    conv(0, 1);
    conv(0, 2);
    start_with(16'h4000);
    repeat (2) @(negedge i_clk);
    check(16'({o_config_error, o_busy}), 16'h0002);
    conv(1, 0);
    check(16'(o_config_error), 16'h0000);
    start_with(16'h0001);
    repeat (3) @(negedge i_clk);
    check(16'({o_analog_on, o_busy}), 16'h0000);
    @(posedge i_clk);
    i_converter_control_reg <= 16'h0000;
    repeat (3) @(posedge i_clk);
    start_with(16'h0000);
    repeat (100) @(posedge i_clk);
    i_converter_control_reg <= 16'h0001;
    seen = 1'b0;
    repeat (300) begin
      @(negedge i_clk);
      seen |= o_result_valid;
    end
    check(16'({seen, o_busy}), 16'h0000);
    complete_run();
  end
endmodule : tb
`default_nettype wire
